//--- crs_pkg.sv
package crs_pkg;
  // Wishbone word addresses of the register window (byte address = 4 * index).
  localparam logic [5:0] ADR_DATA0   = 6'h00;
  localparam logic [5:0] ADR_DATA1   = 6'h01;
  localparam logic [5:0] ADR_DATA2   = 6'h02;
  localparam logic [5:0] ADR_DATA3   = 6'h03;
  localparam logic [5:0] ADR_PTR0    = 6'h04;
  localparam logic [5:0] ADR_PTR1    = 6'h05;
  localparam logic [5:0] ADR_FRAME   = 6'h06;
  localparam logic [5:0] ADR_IP      = 6'h07;
  localparam logic [5:0] ADR_VTB     = 6'h08;
  localparam logic [5:0] ADR_USP     = 6'h09;
  localparam logic [5:0] ADR_ISP     = 6'h0A;
  localparam logic [5:0] ADR_FLAG    = 6'h0B;
  localparam logic [5:0] ADR_SP      = 6'h0C;
  localparam int         NUM_REGS    = 13;
  localparam int         BANKED_REGS = 7;
  localparam int         FLAG_BANK   = 4;
  localparam int         FLAG_STACK  = 7;
  localparam logic [15:0] FLAG_RST   = 16'h0000;
  localparam logic [15:0] FLAG_MASK  = 16'h70FF;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [19:0] ADDR_RST   = 20'h00000;
  localparam int         SWI_LAST    = 31;
  // Datapath write port selector.
  typedef enum logic [3:0] {
    CRS_DST_NONE  = 4'h0,
    CRS_DST_DATA0 = 4'h1,
    CRS_DST_DATA1 = 4'h2,
    CRS_DST_DATA2 = 4'h3,
    CRS_DST_DATA3 = 4'h4,
    CRS_DST_PTR0  = 4'h5,
    CRS_DST_PTR1  = 4'h6,
    CRS_DST_FRAME = 4'h7,
    CRS_DST_USP   = 4'h8,
    CRS_DST_ISP   = 4'h9,
    CRS_DST_SP    = 4'hA,
    CRS_DST_FLAG  = 4'hB,
    CRS_DST_LONGD = 4'hC,
    CRS_DST_LONGH = 4'hD,
    CRS_DST_LONGP = 4'hE
  } crs_dst_type;
endpackage

//--- crs_bank.sv
`timescale 1ns/1ps
// Two-bank storage for the seven duplicated words; one generate entry per word.
module crs_bank #(
  parameter int W = 16,
  parameter int N = 7
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           bank_i,
  input  wire logic [N-1:0]   wr_en_i,
  input  wire logic [N-1:0]   hi_en_i,
  input  wire logic [N-1:0]   lo_en_i,
  input  wire logic [N*W-1:0] wr_data_i,
  output logic      [N*W-1:0] rd_data_o
);
  logic [W-1:0] bank0_r [N];
  logic [W-1:0] bank1_r [N];

  for (genvar g = 0; g < N; g++)
  begin : g_word
    wire logic [W-1:0] cur = bank_i ? bank1_r[g] : bank0_r[g];
    wire logic [W-1:0] wd  = wr_data_i[g*W +: W];
    wire logic [W-1:0] nv  = {hi_en_i[g] ? wd[W-1:W/2] : cur[W-1:W/2],
                              lo_en_i[g] ? wd[W/2-1:0] : cur[W/2-1:0]};
    assign rd_data_o[g*W +: W] = cur;
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        bank0_r[g] <= crs_pkg::WORD_RST;
        bank1_r[g] <= crs_pkg::WORD_RST;
      end
      else if (wr_en_i[g] && !bank_i)
        bank0_r[g] <= nv;
      else if (wr_en_i[g] && bank_i)
        bank1_r[g] <= nv;
    end
  end
endmodule

//--- crs_regset.sv
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Function
// - Thirteen visible registers: seven banked, instruction pointer, vector base, two stacks, flags, active stack pointer.
// - Data, pointer and frame words exist twice, forming two banks.
// - Four data words are 16 bits, readable and writable by the datapath.
// - Data words zero and one have independently writable upper and lower bytes.
// - Long data pairs: word two over zero, word three over one.
// - Two 16-bit pointer words usable as data and as address pointers.
// - Pointer words combine to 32 bits, pointer one forming the upper half.
// - Frame pointer is 16 bits and supplies the frame-relative base.
// - Instruction pointer is 20 bits, addressing the next instruction.
// - Vector table base is 20 bits, the interrupt table start address.
// - Separate 16-bit user and interrupt stack pointers exist.
// - Stack operations use the pointer chosen by flag bit seven.
// - Stack bit zero selects interrupt stack, one selects user stack.
// - Interrupt acknowledge or software interrupt 0 to 31 clears the stack bit.
// - Flag bit four selects the visible bank.
module crs_regset (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone classic slave.
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:2]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // Datapath write port.
  input  wire crs_pkg::crs_dst_type dp_dst_i,
  input  wire logic [1:0]         dp_byte_en_i,
  input  wire logic [31:0]        dp_wdata_i,
  input  wire logic               dp_ip_we_i,
  input  wire logic [23:0]        dp_ip_i,
  input  wire logic               dp_vtb_we_i,
  input  wire logic [23:0]        dp_vtb_i,
  input  wire logic               irq_ack_i,
  input  wire logic               swi_exec_i,
  input  wire logic [5:0]         swi_num_i,
  // Datapath read side.
  output logic      [15:0]        data_word_zero_o,
  output logic      [15:0]        data_word_one_o,
  output logic      [15:0]        data_word_two_o,
  output logic      [15:0]        data_word_three_o,
  output logic      [7:0]         data_zero_upper_byte_o,
  output logic      [7:0]         data_zero_lower_byte_o,
  output logic      [7:0]         data_one_upper_byte_o,
  output logic      [7:0]         data_one_lower_byte_o,
  output logic      [31:0]        long_data_pair_low_o,
  output logic      [31:0]        long_data_pair_high_o,
  output logic      [15:0]        pointer_word_zero_o,
  output logic      [15:0]        pointer_word_one_o,
  output logic      [31:0]        long_pointer_pair_o,
  output logic      [15:0]        frame_pointer_o,
  output logic      [19:0]        instruction_pointer_o,
  output logic      [19:0]        vector_table_base_o,
  output logic      [15:0]        stack_ptr_o,
  output logic      [15:0]        flag_word_o
);
  localparam int NB = crs_pkg::BANKED_REGS;

  logic [15:0] user_stack_ptr_r;
  logic [15:0] irq_stack_ptr_r;
  logic [15:0] flag_word_r;
  logic [19:0] ip_r;
  logic [19:0] vtb_r;
  logic        ack_r;
  logic [31:0] dat_r;

  wire logic [NB*16-1:0] bank_rd;
  wire logic             bank_sel  = flag_word_r[crs_pkg::FLAG_BANK];
  wire logic             stack_sel = flag_word_r[crs_pkg::FLAG_STACK];

  // Bus request qualified; ack falls the cycle after it was given.
  wire logic bus_req = cyc_i && stb_i && !ack_r;
  wire logic bus_wr  = bus_req && we_i;
  wire logic [5:0] badr = adr_i;
  wire logic bw_lo   = bus_wr && sel_i[0];
  wire logic bw_hi   = bus_wr && sel_i[1];
  wire logic bw_any  = bus_wr && (sel_i[0] || sel_i[1]);
  wire logic bw_ext  = bus_wr && sel_i[2];

  // Datapath write decode.
  wire logic dp_d0  = dp_dst_i == crs_pkg::CRS_DST_DATA0;
  wire logic dp_d1  = dp_dst_i == crs_pkg::CRS_DST_DATA1;
  wire logic dp_d2  = dp_dst_i == crs_pkg::CRS_DST_DATA2;
  wire logic dp_d3  = dp_dst_i == crs_pkg::CRS_DST_DATA3;
  wire logic dp_p0  = dp_dst_i == crs_pkg::CRS_DST_PTR0;
  wire logic dp_p1  = dp_dst_i == crs_pkg::CRS_DST_PTR1;
  wire logic dp_fb  = dp_dst_i == crs_pkg::CRS_DST_FRAME;
  wire logic dp_ld  = dp_dst_i == crs_pkg::CRS_DST_LONGD;
  wire logic dp_lh  = dp_dst_i == crs_pkg::CRS_DST_LONGH;
  wire logic dp_lp  = dp_dst_i == crs_pkg::CRS_DST_LONGP;
  wire logic dp_usp = dp_dst_i == crs_pkg::CRS_DST_USP;
  wire logic dp_isp = dp_dst_i == crs_pkg::CRS_DST_ISP;
  wire logic dp_sp  = dp_dst_i == crs_pkg::CRS_DST_SP;
  wire logic dp_flg = dp_dst_i == crs_pkg::CRS_DST_FLAG;
  wire logic dp_act = dp_dst_i != crs_pkg::CRS_DST_NONE;

  // Datapath byte enables apply only to data words zero and one; all other datapath writes are whole.
  wire logic dp_bhi = dp_byte_en_i[1];
  wire logic dp_blo = dp_byte_en_i[0];

  // Per banked word: datapath has priority over the bus in the same cycle.
  wire logic [NB-1:0] dp_we = {dp_fb, dp_p1 | dp_lp, dp_p0 | dp_lp, dp_d3 | dp_lh,
                               dp_d2 | dp_ld, dp_d1 | dp_lh, dp_d0 | dp_ld};
  wire logic [NB-1:0] bus_sel_w;
  wire logic [NB-1:0] bk_we;
  wire logic [NB-1:0] bk_hi;
  wire logic [NB-1:0] bk_lo;
  wire logic [NB*16-1:0] dp_wd;
  wire logic [NB*16-1:0] bk_wd;

  assign dp_wd = {dp_wdata_i[15:0],              // frame
                  dp_lp ? dp_wdata_i[31:16] : dp_wdata_i[15:0],
                  dp_wdata_i[15:0],
                  dp_lh ? dp_wdata_i[31:16] : dp_wdata_i[15:0],
                  dp_ld ? dp_wdata_i[31:16] : dp_wdata_i[15:0],
                  dp_wdata_i[15:0],
                  dp_wdata_i[15:0]};

  for (genvar g = 0; g < NB; g++)
  begin : g_sel
    localparam logic [5:0] GADR = 6'(g);
    wire logic byte_w = (g < 2);
    wire logic dph    = dp_d0 | dp_d1 ? dp_bhi : 1'b1;
    wire logic dpl    = dp_d0 | dp_d1 ? dp_blo : 1'b1;
    assign bus_sel_w[g] = badr == GADR;
    assign bk_we[g] = dp_we[g] | (!dp_act && bw_any && bus_sel_w[g]);
    assign bk_hi[g] = dp_we[g] ? (byte_w ? dph : 1'b1) : bw_hi;
    assign bk_lo[g] = dp_we[g] ? (byte_w ? dpl : 1'b1) : bw_lo;
    assign bk_wd[g*16 +: 16] = dp_we[g] ? dp_wd[g*16 +: 16] : dat_i[15:0];
  end

  crs_bank #(
    .W (16),
    .N (NB)
  ) u_bank (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .bank_i    (bank_sel),
    .wr_en_i   (bk_we),
    .hi_en_i   (bk_hi),
    .lo_en_i   (bk_lo),
    .wr_data_i (bk_wd),
    .rd_data_o (bank_rd)
  );

  // Interrupt entry forces the interrupt stack.
  wire logic swi_low  = swi_exec_i && (swi_num_i <= 6'(crs_pkg::SWI_LAST));
  wire logic stk_clr  = irq_ack_i || swi_low;
  wire logic bus_flg  = !dp_act && bw_any && badr == crs_pkg::ADR_FLAG;
  wire logic [15:0] flg_wd = dp_flg ? dp_wdata_i[15:0] : dat_i[15:0];
  wire logic [15:0] flg_m  = {bus_flg && !sel_i[1] ? flag_word_r[15:8] : flg_wd[15:8],
                              bus_flg && !sel_i[0] ? flag_word_r[7:0]  : flg_wd[7:0]};
  wire logic [15:0] flg_w  = (dp_flg || bus_flg) ? (flg_m & crs_pkg::FLAG_MASK) : flag_word_r;
  wire logic [15:0] flag_nxt = stk_clr ? (flg_w & ~(16'h0001 << crs_pkg::FLAG_STACK)) : flg_w;

  // Active stack pointer write.
  wire logic usp_dp = dp_usp || (dp_sp && stack_sel);
  wire logic isp_dp = dp_isp || (dp_sp && !stack_sel);
  wire logic usp_bus = !dp_act && bw_any &&
                       (badr == crs_pkg::ADR_USP || (badr == crs_pkg::ADR_SP && stack_sel));
  wire logic isp_bus = !dp_act && bw_any &&
                       (badr == crs_pkg::ADR_ISP || (badr == crs_pkg::ADR_SP && !stack_sel));

  // Twenty-bit registers: bits above 19 of any transport are dropped.
  wire logic ip_bus  = !dp_ip_we_i && bw_any && badr == crs_pkg::ADR_IP;
  wire logic vtb_bus = !dp_vtb_we_i && bw_any && badr == crs_pkg::ADR_VTB;
  wire logic [19:0] bus20_ip  = {bw_ext ? dat_i[19:16] : ip_r[19:16],
                                 sel_i[1] ? dat_i[15:8] : ip_r[15:8],
                                 sel_i[0] ? dat_i[7:0] : ip_r[7:0]};
  wire logic [19:0] bus20_vtb = {bw_ext ? dat_i[19:16] : vtb_r[19:16],
                                 sel_i[1] ? dat_i[15:8] : vtb_r[15:8],
                                 sel_i[0] ? dat_i[7:0] : vtb_r[7:0]};

  // Read mux.
  wire logic [15:0] sp_act = stack_sel ? user_stack_ptr_r : irq_stack_ptr_r;
  wire logic [31:0] rd_mux =
    badr < 6'(NB)              ? {16'h0000, bank_rd[badr[2:0]*16 +: 16]} :
    badr == crs_pkg::ADR_IP    ? {12'h000, ip_r} :
    badr == crs_pkg::ADR_VTB   ? {12'h000, vtb_r} :
    badr == crs_pkg::ADR_USP   ? {16'h0000, user_stack_ptr_r} :
    badr == crs_pkg::ADR_ISP   ? {16'h0000, irq_stack_ptr_r} :
    badr == crs_pkg::ADR_FLAG  ? {16'h0000, flag_word_r} :
    badr == crs_pkg::ADR_SP    ? {16'h0000, sp_act} : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_word_r      <= crs_pkg::FLAG_RST;
      user_stack_ptr_r <= crs_pkg::WORD_RST;
      irq_stack_ptr_r  <= crs_pkg::WORD_RST;
      ip_r             <= crs_pkg::ADDR_RST;
      vtb_r            <= crs_pkg::ADDR_RST;
      ack_r            <= 1'b0;
      dat_r            <= 32'h00000000;
    end
    else
    begin
      flag_word_r <= flag_nxt;
      if (usp_dp)
        user_stack_ptr_r <= dp_wdata_i[15:0];
      else if (usp_bus)
        user_stack_ptr_r <= dat_i[15:0];
      if (isp_dp)
        irq_stack_ptr_r <= dp_wdata_i[15:0];
      else if (isp_bus)
        irq_stack_ptr_r <= dat_i[15:0];
      if (dp_ip_we_i)
        ip_r <= dp_ip_i[19:0];
      else if (ip_bus)
        ip_r <= bus20_ip;
      if (dp_vtb_we_i)
        vtb_r <= dp_vtb_i[19:0];
      else if (vtb_bus)
        vtb_r <= bus20_vtb;
      ack_r <= bus_req;
      if (bus_req && !we_i)
        dat_r <= rd_mux;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  assign data_word_zero_o       = bank_rd[15:0];
  assign data_word_one_o        = bank_rd[31:16];
  assign data_word_two_o        = bank_rd[47:32];
  assign data_word_three_o      = bank_rd[63:48];
  assign data_zero_upper_byte_o = bank_rd[15:8];
  assign data_zero_lower_byte_o = bank_rd[7:0];
  assign data_one_upper_byte_o  = bank_rd[31:24];
  assign data_one_lower_byte_o  = bank_rd[23:16];
  assign long_data_pair_low_o   = {bank_rd[47:32], bank_rd[15:0]};
  assign long_data_pair_high_o  = {bank_rd[63:48], bank_rd[31:16]};
  assign pointer_word_zero_o    = bank_rd[79:64];
  assign pointer_word_one_o     = bank_rd[95:80];
  assign long_pointer_pair_o    = {bank_rd[95:80], bank_rd[79:64]};
  assign frame_pointer_o        = bank_rd[111:96];
  assign instruction_pointer_o  = ip_r;
  assign vector_table_base_o    = vtb_r;
  assign stack_ptr_o            = sp_act;
  assign flag_word_o            = flag_word_r;
endmodule

//--- crs_regset_chk.sv
`timescale 1ns/1ps
module crs_regset_chk (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 ack_o,
  input wire crs_pkg::crs_dst_type dp_dst_i,
  input wire logic [31:0]          dp_wdata_i,
  input wire logic                 dp_ip_we_i,
  input wire logic [23:0]          dp_ip_i,
  input wire logic                 irq_ack_i,
  input wire logic                 swi_exec_i,
  input wire logic [5:0]           swi_num_i,
  input wire logic [15:0]          data_word_zero_o,
  input wire logic [15:0]          data_word_two_o,
  input wire logic [7:0]           data_zero_upper_byte_o,
  input wire logic [31:0]          long_data_pair_low_o,
  input wire logic [31:0]          long_pointer_pair_o,
  input wire logic [15:0]          pointer_word_zero_o,
  input wire logic [15:0]          pointer_word_one_o,
  input wire logic [19:0]          instruction_pointer_o,
  input wire logic [15:0]          flag_word_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_PAIR_D: assert property (long_data_pair_low_o == {data_word_two_o, data_word_zero_o})
    else $error("long data pair wrong");
  AST_PAIR_P: assert property (long_pointer_pair_o == {pointer_word_one_o, pointer_word_zero_o})
    else $error("long pointer pair wrong");
  AST_BYTE: assert property (data_zero_upper_byte_o == data_word_zero_o[15:8])
    else $error("upper byte view wrong");
  AST_IRQ: assert property (irq_ack_i |=> !flag_word_o[7])
    else $error("stack bit kept on interrupt");
  AST_SWI: assert property (swi_exec_i && swi_num_i <= crs_pkg::SWI_LAST |=> !flag_word_o[7])
    else $error("stack bit kept on software interrupt");
  AST_DP_W2: assert property (dp_dst_i == crs_pkg::CRS_DST_DATA2
    |=> data_word_two_o == $past(dp_wdata_i[15:0]))
    else $error("datapath word write lost");
  AST_IP: assert property (dp_ip_we_i |=> instruction_pointer_o == $past(dp_ip_i[19:0]))
    else $error("instruction pointer load wrong");
  cover property (irq_ack_i);
  cover property (swi_exec_i && swi_num_i == 6'h1F);
  cover property (flag_word_o[4] && ack_o);
endmodule
bind crs_regset crs_regset_chk CHK (.*);

//--- crs_dp_model.sv
`timescale 1ns/1ps
module crs_dp_model (
  input  wire logic           clk_i,
  output crs_pkg::crs_dst_type dst_o,
  output logic [1:0]          be_o,
  output logic [31:0]         wd_o,
  output logic                ipwe_o,
  output logic [23:0]         ip_o,
  output logic                vtbwe_o,
  output logic [23:0]         vtb_o,
  output logic                irq_o,
  output logic                swi_o,
  output logic [5:0]          num_o
);
  initial
  begin
    dst_o = crs_pkg::CRS_DST_NONE;
    {be_o, wd_o, ipwe_o, ip_o, vtbwe_o, vtb_o, irq_o, swi_o, num_o} = '0;
  end
  // One-cycle request; released data is inverted so stale values never look valid.
  task automatic drive(input crs_pkg::crs_dst_type t, input logic [1:0] e, input logic [31:0] w,
                       input logic iw, input logic [23:0] iv, input logic vw,
                       input logic [23:0] vv, input logic q, input logic s, input logic [5:0] n);
    @(posedge clk_i);
    dst_o <= t;
    {be_o, wd_o, ipwe_o, ip_o, vtbwe_o, vtb_o, irq_o, swi_o, num_o} <= {e, w, iw, iv, vw, vv, q, s, n};
    @(posedge clk_i);
    dst_o <= crs_pkg::CRS_DST_NONE;
    {be_o, wd_o, ip_o, vtb_o, num_o} <= ~{be_o, wd_o, ip_o, vtb_o, num_o};
    {ipwe_o, vtbwe_o, irq_o, swi_o} <= 4'h0;
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic                 clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:2]           adr_i = 6'h00;
  logic [3:0]           sel_i = 4'hF;
  logic [31:0]          dat_i = 32'h00000000, dat_o, dp_wdata_i, long_data_pair_low_o;
  logic [31:0]          long_data_pair_high_o, long_pointer_pair_o;
  crs_pkg::crs_dst_type dp_dst_i;
  logic [1:0]           dp_byte_en_i;
  logic                 dp_ip_we_i, dp_vtb_we_i, irq_ack_i, swi_exec_i;
  logic [23:0]          dp_ip_i, dp_vtb_i;
  logic [5:0]           swi_num_i;
  logic [15:0]          data_word_zero_o, data_word_one_o, data_word_two_o, data_word_three_o;
  logic [15:0]          pointer_word_zero_o, pointer_word_one_o, frame_pointer_o;
  logic [15:0]          stack_ptr_o, flag_word_o;
  logic [7:0]           data_zero_upper_byte_o, data_zero_lower_byte_o;
  logic [7:0]           data_one_upper_byte_o, data_one_lower_byte_o;
  logic [19:0]          instruction_pointer_o, vector_table_base_o;
  logic [15:0]          bk [2][7] = '{default: 16'h0000};
  logic [15:0]          user_stack_ptr = 16'h0000, irq_stack_ptr = 16'h0000, flag_word = 16'h0000;
  logic [19:0]          ip = 20'h00000, vtb = 20'h00000;
  int                   n_errors = 0, total_checks = 0;
  always #25 clk_i = ~clk_i;
  crs_regset DUT (.*);
  crs_dp_model DPM (.clk_i, .dst_o(dp_dst_i), .be_o(dp_byte_en_i), .wd_o(dp_wdata_i),
    .ipwe_o(dp_ip_we_i), .ip_o(dp_ip_i), .vtbwe_o(dp_vtb_we_i), .vtb_o(dp_vtb_i),
    .irq_o(irq_ack_i), .swi_o(swi_exec_i), .num_o(swi_num_i));
  task automatic results();
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] exp_rd(input int a);
    if (a < 7) return {16'h0000, bk[flag_word[4]][a]};
    case (a)
      7: return {12'h000, ip};
      8: return {12'h000, vtb};
      9: return {16'h0000, user_stack_ptr};
      10: return {16'h0000, irq_stack_ptr};
      11: return {16'h0000, flag_word};
      12: return {16'h0000, flag_word[7] ? user_stack_ptr : irq_stack_ptr};
      default: return 32'h00000000;
    endcase
  endfunction
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    chk("ack", {31'h0, ack_o}, 32'h1);
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a[5:0], d, q);
    if (a < 7) bk[flag_word[4]][a] = d[15:0];
    else if (a == 7) ip = d[19:0];
    else if (a == 8) vtb = d[19:0];
    else if (a == 9 || (a == 12 && flag_word[7])) user_stack_ptr = d[15:0];
    else if (a == 10 || a == 12) irq_stack_ptr = d[15:0];
    else if (a == 11) flag_word = d[15:0] & crs_pkg::FLAG_MASK;
  endtask
  task automatic rd(input int a);
    logic [31:0] q;
    wb(1'b0, a[5:0], 32'h00000000, q);
    chk("bus read", q, exp_rd(a));
  endtask
  task automatic chk_out();
    logic b;
    @(negedge clk_i);
    b = flag_word[4];
    chk("data01", {data_word_one_o, data_word_zero_o}, {bk[b][1], bk[b][0]});
    chk("data23", {data_word_three_o, data_word_two_o}, {bk[b][3], bk[b][2]});
    chk("ptrs", {pointer_word_one_o, pointer_word_zero_o}, {bk[b][5], bk[b][4]});
    chk("frame sp", {frame_pointer_o, stack_ptr_o}, {bk[b][6], flag_word[7] ? user_stack_ptr : irq_stack_ptr});
    chk("ip", {12'h000, instruction_pointer_o}, {12'h000, ip});
    chk("vtb", {12'h000, vector_table_base_o}, {12'h000, vtb});
    chk("flag", {16'h0000, flag_word_o}, {16'h0000, flag_word});
    chk("long low", long_data_pair_low_o, {bk[b][2], bk[b][0]});
    chk("long high", long_data_pair_high_o, {bk[b][3], bk[b][1]});
    chk("long ptr", long_pointer_pair_o, {bk[b][5], bk[b][4]});
    chk("bytes", {data_zero_upper_byte_o, data_zero_lower_byte_o, data_one_upper_byte_o,
        data_one_lower_byte_o}, {bk[b][0], bk[b][1]});
  endtask
  task automatic dp(input crs_pkg::crs_dst_type t, input logic [1:0] e, input logic [31:0] w);
    logic b;
    b = flag_word[4];
    DPM.drive(t, e, w, 1'b0, 24'h000000, 1'b0, 24'h000000, 1'b0, 1'b0, 6'h00);
    case (t)
      crs_pkg::CRS_DST_DATA0, crs_pkg::CRS_DST_DATA1:
      begin
        if (e[1]) bk[b][t - 1][15:8] = w[15:8];
        if (e[0]) bk[b][t - 1][7:0] = w[7:0];
      end
      crs_pkg::CRS_DST_LONGD: {bk[b][2], bk[b][0]} = w;
      crs_pkg::CRS_DST_LONGH: {bk[b][3], bk[b][1]} = w;
      crs_pkg::CRS_DST_LONGP: {bk[b][5], bk[b][4]} = w;
      default: bk[b][t - 1] = w[15:0];
    endcase
    chk_out();
  endtask
  initial
  begin
    #1000000;
    n_errors++;
    results();
  end
  initial
  begin
    logic [31:0] w;
    void'($urandom(80227));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) rd(i);
    for (int b = 0; b < 2; b++)
    begin
      wr(11, b << 4);
      for (int i = 0; i < 11; i++) wr(i, $urandom);
      for (int t = 1; t < 15; t++) if (t < 8 || t > 11) dp(crs_pkg::crs_dst_type'(t), 2'(t), $urandom);
    end
    wr(13, $urandom);
    for (int b = 0; b < 3; b++)
    begin
      wr(11, (b == 2) ? $urandom : b << 4);
      for (int i = 0; i < 14; i++) rd(i);
    end
    repeat (4)
    begin
      w = $urandom;
      DPM.drive(crs_pkg::CRS_DST_NONE, 2'b00, 32'h0, 1'b1, w[23:0], 1'b1, w[31:8], 1'b0, 1'b0, 6'h00);
      ip = w[19:0];
      vtb = w[27:8];
      chk_out();
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(11, 32'h00000090);
      wr(12, $urandom);
      rd(9);
      rd(10);
      DPM.drive(crs_pkg::CRS_DST_NONE, 2'b00, 32'h0, 1'b0, 24'h0, 1'b0, 24'h0, k == 2, k < 2,
                (k == 0) ? 6'h1F : 6'h20);
      if (k != 1) flag_word[7] = 1'b0;
      chk_out();
    end
    results();
  end
endmodule
